// ==== verilog/rtc_pkg.sv ====
// Shared constants and state types for the real-time counter core.
// Assumes an APB register bus with 32-bit data and one clock domain.
package rtc_pkg;

    // Register indexes; the byte address is four times the index.
    localparam logic [5:0] IDX_CTRL   = 6'h00;
    localparam logic [5:0] IDX_RDREQ  = 6'h02;
    localparam logic [5:0] IDX_EVENT_OUTPUT_CONTROL = 6'h04;
    localparam logic [5:0] IDX_IENCLR = 6'h06;
    localparam logic [5:0] IDX_IENSET = 6'h07;
    localparam logic [5:0] IDX_FLAGS  = 6'h08;
    localparam logic [5:0] IDX_STATUS = 6'h0A;
    localparam logic [5:0] IDX_DBG    = 6'h0B;
    localparam logic [5:0] IDX_FCORR  = 6'h0C;
    localparam logic [5:0] IDX_COUNT  = 6'h10;
    localparam logic [5:0] IDX_PER    = 6'h14;
    localparam logic [5:0] IDX_COMPARE_ZERO  = 6'h18;
    localparam logic [5:0] IDX_COMPARE_ONE_16  = 6'h1A;

    // Control register field positions.
    localparam int C_SOFT_RESET_BIT  = 0;
    localparam int C_EN     = 1;
    localparam int C_MODE   = 2;
    localparam int C_HOUR12 = 6;
    localparam int C_CLRM   = 7;
    localparam int C_PRESC  = 8;

    // Interrupt flag and mask positions.
    localparam int F_COMPARE_ZERO_FLAG = 0;
    localparam int F_CMP1 = 1;
    localparam int F_SYNC = 6;
    localparam int F_OVF  = 7;

    // Event control positions, status busy bit and debug run bit.
    localparam int E_COMPARE_ZERO_FLAG = 8;
    localparam int E_CMP1 = 9;
    localparam int E_OVF  = 15;
    localparam int S_BUSY = 7;
    localparam int D_RUN  = 0;
    localparam int R_RREQ = 15;

    // Operating modes.
    localparam logic [1:0] MODE_CNT32 = 2'h0;
    localparam logic [1:0] MODE_CNT16 = 2'h1;

    // Calendar limits.
    localparam logic [5:0] SEC_MAX   = 6'h3B;
    localparam logic [4:0] HOUR_MAX  = 5'h17;
    localparam logic [3:0] H12_TOP   = 4'hC;
    localparam logic [3:0] H12_LAST  = 4'hB;
    localparam logic [3:0] MON_MAX   = 4'hC;
    localparam logic [3:0] MON_FEB   = 4'h2;
    localparam logic [15:0] MON30    = 16'h0A50;
    localparam logic [4:0] DAYS_31   = 5'h1F;
    localparam logic [4:0] DAYS_30   = 5'h1E;
    localparam logic [4:0] DAYS_29   = 5'h1D;
    localparam logic [4:0] DAYS_28   = 5'h1C;

    // Calendar word layout.
    typedef struct packed {
        logic [5:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic [4:0] hour;
        logic [5:0] minute;
        logic [5:0] second;
    } cal_s;

    // Whole state of the counter core.
    typedef struct packed {
        logic        sync1;
        logic        sync2;
        logic        srcPrev;
        logic        enable;
        logic        clrMatch;
        logic        hour12;
        logic [1:0]  mode;
        logic [3:0]  presc;
        logic [15:0] read_request;
        logic [15:0] event_output_control;
        logic [7:0]  intMask;
        logic [7:0]  flags;
        logic [7:0]  frequency_correction;
        logic        runHalt;
        logic [31:0] count;
        logic [31:0] compare_zero;
        logic [15:0] per;
        logic [15:0] compare_one_16;
        logic        pendWr;
        logic [31:0] pendVal;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
        logic        ovfEv;
        logic        cmp0Ev;
        logic        cmp1Ev;
        logic [7:0]  perEv;
    } rtc_state_s;

    localparam rtc_state_s STATE_RST = '0;

endpackage

// ==== verilog/count_prescaler.sv ====
// Divides the synchronised source-clock edge pulse by a power of two.
// Assumes srcTick is a one-cycle pulse in the clk domain.
`timescale 1ns/100ps
`default_nettype none
module count_prescaler #(
    parameter int DIV_W = 15,
    parameter int PS_W  = 4,
    parameter int PER_N = 8
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic             clear,
    input  wire logic             srcTick,
    input  wire logic [PS_W-1:0]  prescale,
    output logic                  cntTick,
    output logic [PER_N-1:0]      perTick
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
    } prsc_state_s;

    prsc_state_s st_reg;
    prsc_state_s st_next;
    logic [DIV_W-1:0] mask;
    logic [DIV_W-1:0] pmask;

    // divide by power. A tick leaves when all selected low bits are ones.
    always_comb begin
        st_next = st_reg;
        mask    = ~({DIV_W{1'b1}} << prescale);
        cntTick = srcTick && ((st_reg.div & mask) == mask);
        for (int i = 0; i < PER_N; i++) begin
            pmask      = ~({DIV_W{1'b1}} << (i + 1));
            perTick[i] = srcTick && ((st_reg.div & pmask) == pmask);
        end
        if (clear) begin
            st_next.div = '0;
        end else if (srcTick) begin
            st_next.div = st_reg.div + 1'b1;
        end
    end

    // Registers the divider state.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule
`default_nettype wire

// ==== verilog/calendar_step.sv ====
// Advances a packed calendar word by one second.
// Assumes the word holds valid values; purely combinational.
`timescale 1ns/100ps
`default_nettype none
module calendar_step (
    input  wire logic [31:0] timeIn,
    input  wire logic        hour12,
    output logic [31:0]      timeOut
);

    rtc_pkg::cal_s t;
    rtc_pkg::cal_s n;
    logic          carry;
    logic [4:0]    dim;

    // calendar carries. Each field rolls into the next one up.
    always_comb begin
        t     = rtc_pkg::cal_s'(timeIn);
        n     = t;
        carry = 1'b0;
        dim   = rtc_pkg::DAYS_31;
        if (t.month == rtc_pkg::MON_FEB) begin
            dim = (t.year[1:0] == 2'h0) ? rtc_pkg::DAYS_29 : rtc_pkg::DAYS_28;
        end else if (rtc_pkg::MON30[t.month]) begin
            dim = rtc_pkg::DAYS_30;
        end
        if (t.second == rtc_pkg::SEC_MAX) begin
            n.second = '0;
            if (t.minute == rtc_pkg::SEC_MAX) begin
                n.minute = '0;
                if (hour12) begin
                    // Twelve-hour form: bit 4 marks the afternoon.
                    if (t.hour[3:0] == rtc_pkg::H12_TOP) begin
                        n.hour = {t.hour[4], 4'h1};
                    end else if (t.hour[3:0] == rtc_pkg::H12_LAST) begin
                        n.hour = {~t.hour[4], rtc_pkg::H12_TOP};
                        carry  = t.hour[4];
                    end else begin
                        n.hour = t.hour + 5'h01;
                    end
                end else if (t.hour == rtc_pkg::HOUR_MAX) begin
                    n.hour = '0;
                    carry  = 1'b1;
                end else begin
                    n.hour = t.hour + 5'h01;
                end
            end else begin
                n.minute = t.minute + 6'h01;
            end
        end else begin
            n.second = t.second + 6'h01;
        end
        if (carry) begin
            if (t.day >= dim) begin
                n.day = 5'h01;
                if (t.month >= rtc_pkg::MON_MAX) begin
                    n.month = 4'h1;
                    n.year  = t.year + 6'h01;
                end else begin
                    n.month = t.month + 4'h1;
                end
            end else begin
                n.day = t.day + 5'h01;
            end
        end
        timeOut = 32'(n);
    end

endmodule
`default_nettype wire

// ==== verilog/rtc_counter_core.sv ====
// Real-time counter core with APB registers, three counting modes,
// sticky interrupt flags and event pulses.
// Assumes one 125 MHz clock; the source clock arrives as a slow pin.
//
// Notes on behaviour
// - Counting rate is source clock divided by two to the prescaler setting.
// - Control enable bit one starts counting, zero stops it.
// - Soft reset restores all registers except debug control; counter left disabled.
// - Mode field: zero 32-bit, one 16-bit, otherwise calendar.
// - In 32-bit mode enabled counter increments on each counting tick.
// - In 32-bit mode all-ones wraps to zero and sets overflow flag.
// - In 32-bit mode the full counter is readable and writable.
// - Compare zero match sets its flag on the next counting tick.
// - In 32-bit mode with clear-on-match the counter returns to zero after a match.
// - In 32-bit mode with clear-on-match a match sets compare and overflow flags together.
// - In 16-bit mode counter increments up to the period register.
// - Sync busy rises when a cross-domain transfer starts, falls when done.
// - Counter halts in debug unless run-while-halted is set.
`timescale 1ns/100ps
`default_nettype none
module rtc_counter_core #(
    parameter int DIV_W = 15,
    parameter int PER_N = 8
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        srcClkPin,
    input  wire logic        dbgHalt,
    output logic             irq,
    output logic             ovfEvent,
    output logic             cmp0Event,
    output logic             cmp1Event,
    output logic [PER_N-1:0] perEvent
);

    rtc_pkg::rtc_state_s st_reg;
    rtc_pkg::rtc_state_s st_next;

    logic             srcTick;
    logic             cntTick;
    logic [PER_N-1:0] perTick;
    logic [31:0]      calNext;
    logic [5:0]       idx;
    logic             accessHit;
    logic             wrEn;
    logic             swrstHit;

    // Bus decode shared by the core and the prescaler clear.
    assign idx       = paddr[7:2];
    assign accessHit = psel & penable;
    assign wrEn      = accessHit & pwrite & st_reg.pready;
    assign srcTick   = st_reg.sync2 & ~st_reg.srcPrev;

    // soft reset strobe. Also restarts the prescaler.
    assign swrstHit = wrEn && (idx == rtc_pkg::IDX_CTRL) && (paddr[1:0] == 2'h0)
                      && pwdata[rtc_pkg::C_SOFT_RESET_BIT];

    count_prescaler #(
        .DIV_W (DIV_W),
        .PS_W  (4),
        .PER_N (PER_N)
    ) u_prescaler (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .clear    (swrstHit),
        .srcTick  (srcTick),
        .prescale (st_reg.presc),
        .cntTick  (cntTick),
        .perTick  (perTick)
    );

    calendar_step u_calendar (
        .timeIn  (st_reg.count),
        .hour12  (st_reg.hour12),
        .timeOut (calNext)
    );

    // Next-state logic: synchroniser, bus slave, counting and flags.
    always_comb begin
        logic        mapped;
        logic [31:0] rdVal;
        logic        tick;
        logic        match0;
        logic        match1;
        logic [7:0]  setFlags;
        logic [7:0]  clrFlags;
        logic [31:0] wrVal;

        st_next  = st_reg;
        mapped   = 1'b1;
        rdVal    = '0;
        setFlags = '0;
        clrFlags = '0;
        wrVal    = pwdata;

        // The source clock pin passes two flip-flops before edge detection.
        st_next.sync1   = srcClkPin;
        st_next.sync2   = st_reg.sync1;
        st_next.srcPrev = st_reg.sync2;

        // Read mux; an unaligned or unknown address is refused.
        case (idx)
            rtc_pkg::IDX_CTRL: begin
                rdVal[rtc_pkg::C_EN]            = st_reg.enable;
                rdVal[rtc_pkg::C_MODE +: 2]     = st_reg.mode;
                rdVal[rtc_pkg::C_HOUR12]        = st_reg.hour12;
                rdVal[rtc_pkg::C_CLRM]          = st_reg.clrMatch;
                rdVal[rtc_pkg::C_PRESC +: 4]    = st_reg.presc;
            end
            rtc_pkg::IDX_RDREQ:  rdVal = 32'(st_reg.read_request);
            rtc_pkg::IDX_EVENT_OUTPUT_CONTROL: rdVal = 32'(st_reg.event_output_control);
            rtc_pkg::IDX_IENCLR: rdVal = 32'(st_reg.intMask);
            rtc_pkg::IDX_IENSET: rdVal = 32'(st_reg.intMask);
            rtc_pkg::IDX_FLAGS:  rdVal = 32'(st_reg.flags);
            // busy shown. High while a counter write waits for a tick.
            rtc_pkg::IDX_STATUS: rdVal[rtc_pkg::S_BUSY] = st_reg.pendWr;
            rtc_pkg::IDX_DBG:    rdVal[rtc_pkg::D_RUN] = st_reg.runHalt;
            rtc_pkg::IDX_FCORR:  rdVal = 32'(st_reg.frequency_correction);
            // full counter read. Only 16 bits show in 16-bit mode.
            rtc_pkg::IDX_COUNT: begin
                if (st_reg.mode == rtc_pkg::MODE_CNT16) begin
                    rdVal = 32'(st_reg.count[15:0]);
                end else begin
                    rdVal = st_reg.count;
                end
            end
            rtc_pkg::IDX_PER: rdVal = 32'(st_reg.per);
            rtc_pkg::IDX_COMPARE_ZERO: begin
                if (st_reg.mode == rtc_pkg::MODE_CNT32) begin
                    rdVal = st_reg.compare_zero;
                end else begin
                    rdVal = 32'(st_reg.compare_zero[15:0]);
                end
            end
            rtc_pkg::IDX_COMPARE_ONE_16: rdVal = 32'(st_reg.compare_one_16);
            default: mapped = 1'b0;
        endcase
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end

        // One wait state: answer is registered on the first access cycle.
        st_next.pready  = accessHit & ~st_reg.pready;
        st_next.pslverr = accessHit & ~st_reg.pready & ~mapped;
        st_next.prdata  = (accessHit & ~st_reg.pready & ~pwrite & mapped) ? rdVal : '0;

        // debug halt. Counting pauses unless run-while-halted is set.
        tick   = cntTick & st_reg.enable & ~(dbgHalt & ~st_reg.runHalt);
        match0 = 1'b0;
        match1 = 1'b0;

        // mode select. The mode field picks the counting rule.
        if (tick) begin
            case (st_reg.mode)
                rtc_pkg::MODE_CNT32: begin
                    match0 = (st_reg.count == st_reg.compare_zero);
                    // compare flag. Set on the tick after equality.
                    setFlags[rtc_pkg::F_COMPARE_ZERO_FLAG] = match0;
                    if (match0 && st_reg.clrMatch) begin
                        // clear on match. both flags set together.
                        st_next.count            = '0;
                        setFlags[rtc_pkg::F_OVF] = 1'b1;
                    end else begin
                        // increment per tick. wrap sets overflow.
                        st_next.count            = st_reg.count + 32'h00000001;
                        setFlags[rtc_pkg::F_OVF] = &st_reg.count;
                    end
                end
                rtc_pkg::MODE_CNT16: begin
                    match0 = (st_reg.count[15:0] == st_reg.compare_zero[15:0]);
                    match1 = (st_reg.count[15:0] == st_reg.compare_one_16);
                    setFlags[rtc_pkg::F_COMPARE_ZERO_FLAG] = match0;
                    setFlags[rtc_pkg::F_CMP1] = match1;
                    if (st_reg.count[15:0] == st_reg.per) begin
                        // period wrap. Back to zero with overflow.
                        st_next.count            = '0;
                        setFlags[rtc_pkg::F_OVF] = 1'b1;
                    end else begin
                        // count to period. Period register is the top.
                        st_next.count = 32'(st_reg.count[15:0] + 16'h0001);
                    end
                end
                default: begin
                    // calendar tick. makes each tick one second.
                    st_next.count = calNext;
                end
            endcase
        end

        // sync completes. A pending counter write lands on a counting tick.
        if (cntTick && st_reg.pendWr) begin
            st_next.count            = st_reg.pendVal;
            st_next.pendWr           = 1'b0;
            setFlags[rtc_pkg::F_SYNC] = 1'b1;
        end

        // Register writes take effect at the edge that completes the access.
        if (wrEn && mapped) begin
            case (idx)
                rtc_pkg::IDX_CTRL: begin
                    // enable bit. One starts, zero stops counting.
                    st_next.enable   = pwdata[rtc_pkg::C_EN];
                    st_next.mode     = pwdata[rtc_pkg::C_MODE +: 2];
                    st_next.hour12   = pwdata[rtc_pkg::C_HOUR12];
                    st_next.clrMatch = pwdata[rtc_pkg::C_CLRM];
                    st_next.presc    = pwdata[rtc_pkg::C_PRESC +: 4];
                end
                rtc_pkg::IDX_RDREQ: begin
                    st_next.read_request                 = pwdata[15:0];
                    st_next.read_request[rtc_pkg::R_RREQ] = 1'b0;
                end
                rtc_pkg::IDX_EVENT_OUTPUT_CONTROL: st_next.event_output_control = pwdata[15:0];
                rtc_pkg::IDX_IENCLR: st_next.intMask = st_reg.intMask & ~pwdata[7:0];
                rtc_pkg::IDX_IENSET: st_next.intMask = st_reg.intMask | pwdata[7:0];
                rtc_pkg::IDX_FLAGS:  clrFlags = pwdata[7:0];
                rtc_pkg::IDX_DBG:    st_next.runHalt = pwdata[rtc_pkg::D_RUN];
                rtc_pkg::IDX_FCORR:  st_next.frequency_correction = pwdata[7:0];
                rtc_pkg::IDX_COUNT: begin
                    // counter write. busy until the next tick.
                    if (st_reg.mode == rtc_pkg::MODE_CNT16) begin
                        wrVal = 32'(pwdata[15:0]);
                    end
                    st_next.pendWr  = 1'b1;
                    st_next.pendVal = wrVal;
                end
                rtc_pkg::IDX_PER: st_next.per = pwdata[15:0];
                rtc_pkg::IDX_COMPARE_ZERO: begin
                    if (st_reg.mode == rtc_pkg::MODE_CNT32) begin
                        st_next.compare_zero = pwdata;
                    end else begin
                        st_next.compare_zero = 32'(pwdata[15:0]);
                    end
                end
                rtc_pkg::IDX_COMPARE_ONE_16: st_next.compare_one_16 = pwdata[15:0];
                default: begin
                end
            endcase
        end

        // Sticky flags: a set in the same cycle as its clear wins.
        st_next.flags = (st_reg.flags & ~clrFlags) | setFlags;

        // Event pulses follow the events that set the flags; period pulses follow the prescaler taps.
        st_next.ovfEv  = setFlags[rtc_pkg::F_OVF] & st_reg.event_output_control[rtc_pkg::E_OVF];
        st_next.cmp0Ev = setFlags[rtc_pkg::F_COMPARE_ZERO_FLAG] & st_reg.event_output_control[rtc_pkg::E_COMPARE_ZERO_FLAG];
        st_next.cmp1Ev = setFlags[rtc_pkg::F_CMP1] & st_reg.event_output_control[rtc_pkg::E_CMP1];
        st_next.perEv  = perTick & st_reg.event_output_control[PER_N-1:0];

        // Interrupt is high while any unmasked flag is set.
        st_next.irq = |(st_next.flags & st_next.intMask);

        // soft reset. Everything but debug control, the synchroniser and bus ready returns.
        // software has already cleared enable; reset forces it off anyway.
        if (swrstHit) begin
            st_next         = rtc_pkg::STATE_RST;
            st_next.sync1   = srcClkPin;
            st_next.sync2   = st_reg.sync1;
            st_next.srcPrev = st_reg.sync2;
            st_next.runHalt = st_reg.runHalt;
            st_next.pready  = accessHit & ~st_reg.pready;
            st_next.pslverr = 1'b0;
            st_next.prdata  = '0;
        end
    end

    // Registers the whole core state.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= rtc_pkg::STATE_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign prdata    = st_reg.prdata;
    assign pready    = st_reg.pready;
    assign pslverr   = st_reg.pslverr;
    assign irq       = st_reg.irq;
    assign ovfEvent  = st_reg.ovfEv;
    assign cmp0Event = st_reg.cmp0Ev;
    assign cmp1Event = st_reg.cmp1Ev;
    assign perEvent  = st_reg.perEv;

endmodule
`default_nettype wire

// ==== sim/rtc_core_sva.sv ====
// Port checker for the real-time counter core, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module rtc_core_sva #(
    parameter int PER_N = 8
) (
    input wire logic             clk,
    input wire logic             sys_rst,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [7:0]       paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             irq,
    input wire logic             ovfEvent,
    input wire logic             cmp0Event,
    input wire logic [PER_N-1:0] perEvent
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // First access cycle of a transfer, and a committed soft reset write.
    sequence accessStart;
        psel && penable && !$past(penable);
    endsequence
    sequence softReset;
        psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[0];
    endsequence
    answer_timing_a: assert property (accessStart |=> pready)
        else $error("No answer one cycle after access start.");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    error_with_ready_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("Error answer without ready or with data.");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("Read data outside the answer cycle.");
    unaligned_refused_a: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("Unaligned access was not refused.");
    soft_reset_quiet_a: assert property (softReset |-> ##2 !irq)
        else $error("Interrupt still high after soft reset.");
    ovf_pulse_a: assert property (ovfEvent |=> !ovfEvent)
        else $error("Overflow event longer than one cycle.");
    cmp_pulse_a: assert property (cmp0Event |=> !cmp0Event)
        else $error("Compare event longer than one cycle.");
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> !irq && perEvent == '0)
        else $error("Outputs active after reset.");
endmodule
bind rtc_counter_core rtc_core_sva #(.PER_N(PER_N)) sva (.clk(clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .ovfEvent(ovfEvent), .cmp0Event(cmp0Event), .perEvent(perEvent));
`default_nettype wire

// ==== sim/rtc_counter_core_bench.sv ====
// Self-checking bench for the real-time counter core.
// Assumes the core and its checker are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x); end end
module rtc_counter_core_bench;
    logic clk, sysRst, psel, penable, pwrite, srcClkPin, dbgHalt, pready, pslverr;
    logic irq, ovfEvent, cmp0Event, cmp1Event, e;
    logic [7:0]  paddr, perEv;
    logic [31:0] pwdata, prdata, r;
    int error_cnt, n_tests, cyc, ovfN, cmpN, c1N, perN, p, n, m;
    rtc_counter_core DUT (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .srcClkPin(srcClkPin), .dbgHalt(dbgHalt), .irq(irq),
        .ovfEvent(ovfEvent), .cmp0Event(cmp0Event), .cmp1Event(cmp1Event),
        .perEvent(perEv));
    // Prints the counts and the verdict, then stops the run.
    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One APB transfer; holds the request until ready is sampled high.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) error_cnt++;
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(r, x)
    endtask
    // Source clock rising edges, each phase three cycles, then sync settling.
    task automatic edges(input int cnt);
        repeat (cnt) begin
            srcClkPin <= 1'b1; repeat (3) @(posedge clk);
            srcClkPin <= 1'b0; repeat (3) @(posedge clk);
        end
        repeat (4) @(posedge clk);
    endtask
    // Soft reset, always issued with the counter already stopped.
    task automatic sr();
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h1);
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Cycle limit and event pulse counting.
    always @(posedge clk) begin
        cyc++;
        if (ovfEvent) ovfN++;
        if (cmp0Event) cmpN++;
        if (cmp1Event) c1N++;
        if (perEv[0]) perN++;
        if (cyc > 20000) begin error_cnt++; complete_run(); end
    end
    initial begin
        {psel, penable, pwrite, srcClkPin, dbgHalt} = '0;
        paddr = 8'h00; pwdata = 32'h0; sysRst = 1'b1;
        p = $urandom(32'hE3ECF228);
        repeat (6) @(posedge clk);
        sysRst <= 1'b0;
        // Plain 32-bit counting through the prescaler, then stopping.
        p = $urandom_range(2); n = (1 << p) * (2 + $urandom_range(3));
        wr(8'h00, 32'h2 | 32'(p << 8));
        edges(n); rdChk(8'h40, 32'(n >> p));
        wr(8'h00, 32'(p << 8)); edges(2); rdChk(8'h40, 32'(n >> p));
        // Counter write, wrap with overflow, interrupt raise, mask and clear.
        sr(); wr(8'h60, 32'h12345678); wr(8'h1C, 32'h80);
        wr(8'h40, 32'hFFFFFFFE); rdChk(8'h28, 32'h80);
        edges(1); rdChk(8'h28, 32'h0); rdChk(8'h40, 32'hFFFFFFFE);
        wr(8'h00, 32'h2); edges(2); rdChk(8'h40, 32'h0); rdChk(8'h20, 32'hC0);
        `CHK(irq, 1'b1)
        wr(8'h18, 32'h80); repeat (2) @(posedge clk); `CHK(irq, 1'b0)
        wr(8'h1C, 32'h80); repeat (2) @(posedge clk); `CHK(irq, 1'b1)
        wr(8'h20, 32'hC0); repeat (2) @(posedge clk); `CHK(irq, 1'b0)
        apb(1'b0, 8'h24, 32'h0); `CHK(e, 1'b1)
        apb(1'b0, 8'h01, 32'h0); `CHK(e, 1'b1)
        // Compare match with clear-on-match and event outputs.
        sr(); n = 2 + $urandom_range(3);
        wr(8'h60, 32'(n)); wr(8'h10, 32'h8100); wr(8'h00, 32'h82);
        edges(n + 1); rdChk(8'h40, 32'h0); rdChk(8'h20, 32'h81);
        `CHK(ovfN, 1) `CHK(cmpN, 1)
        // 16-bit counting up to the period, then wrapping.
        sr(); p = 3 + $urandom_range(3);
        wr(8'h50, 32'(p)); wr(8'h60, 32'hFFFF); wr(8'h68, 32'h1); wr(8'h10, 32'h0201);
        wr(8'h00, 32'h6); c1N = 0; perN = 0;
        edges(p + 3); rdChk(8'h40, 32'h2); rdChk(8'h20, 32'h82);
        `CHK(c1N, 2) `CHK(perN, (p + 3) / 2)
        // Debug halt, run-while-halted, and its survival of soft reset.
        sr(); dbgHalt <= 1'b1; wr(8'h00, 32'h2); edges(3); rdChk(8'h40, 32'h0);
        wr(8'h2C, 32'h1); edges(3); rdChk(8'h40, 32'h3);
        sr(); rdChk(8'h2C, 32'h1); rdChk(8'h00, 32'h0); rdChk(8'h1C, 32'h0);
        dbgHalt <= 1'b0;
        // Calendar carry from the last second of a day, in both calendar modes.
        for (m = 2; m < 4; m++) begin
            sr(); wr(8'h40, {6'h01, 4'h3, 5'h05, ((m == 3) ? 5'h1B : 5'h17), 6'h3B, 6'h3B});
            edges(1);
            wr(8'h00, 32'(m << 2) | ((m == 3) ? 32'h40 : 32'h0));
            wr(8'h00, 32'h2 | 32'(m << 2) | ((m == 3) ? 32'h40 : 32'h0)); edges(1);
            rdChk(8'h40, {6'h01, 4'h3, 5'h06, ((m == 3) ? 5'h0C : 5'h00), 12'h000});
        end
        complete_run();
    end
endmodule
`default_nettype wire
